// >>> include/vrs_pkg.sv
// Constants, register map and carrier types for the reader setup decoder.
package vrs_pkg;
  localparam int NUM_READERS = 3;
  localparam int LINE_W = 10;
  localparam int AW = 8;

  localparam logic [7:0] ADDR_ASSIGN = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [3:0] RDR_PAGE_FIRST = 4'h1;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_LINES = 4'h4;
  localparam logic [3:0] OFS_TIME = 4'h8;
  localparam logic [3:0] OFS_USER = 4'hC;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CRC_ALT_BIT = 3;
  localparam int CFG_FILM_TYPE_LSB = 4;
  localparam int CFG_FILM_RATE_LSB = 8;
  localparam int CFG_EDGE_STYLE_BIT = 10;
  localparam int CFG_EDGE_FMT_LSB = 11;
  localparam int LINES_START_LSB = 0;
  localparam int LINES_END_LSB = 16;
  localparam int STAT_VALID_LSB = 0;
  localparam int STAT_CRCERR_LSB = 4;

  localparam logic [LINE_W-1:0] LINE_START_RST = 10'h00A;
  localparam logic [LINE_W-1:0] LINE_END_RST = 10'h014;

  typedef enum logic [2:0] {
    ASG_LTC_VITC_OFF,
    ASG_VITC_VITC_OFF,
    ASG_VITC_X3,
    ASG_AUTO_OFF_OFF,
    ASG_THREE_LINE
  } vrs_asgn_t;

  typedef enum logic [2:0] {
    MODE_TIME_DATA,
    MODE_TIME_TIME,
    MODE_TIME_EDGE,
    MODE_KEY_INFO_PLUS_EDGE,
    MODE_DATA_DATA,
    MODE_TIME_DATE
  } vrs_mode_t;

  typedef enum logic [1:0] {TK_TIME, TK_NUMERIC, TK_KEY_INFO} vrs_tkind_t;
  typedef enum logic [1:0] {UK_NUMERIC, UK_TIME, UK_EDGE, UK_DATE} vrs_ukind_t;
  typedef enum logic [1:0] {
    CRC_STANDARD,
    CRC_FILM_KEY,
    CRC_CHECKSUM_A
  } vrs_crc_t;

  localparam vrs_mode_t FORCED_MODE = MODE_TIME_DATA;
  localparam logic FORCED_CRC_ALT = 1'b1;
  localparam logic FORCED_EDGE_STYLE = 1'b1;
  localparam logic [1:0] FORCED_EDGE_FMT = 2'h0;

  typedef struct packed {
    vrs_mode_t mode;
    logic crc_alt;
    logic [3:0] film_type;
    logic [1:0] film_rate;
    logic edge_style;
    logic [1:0] edge_fmt;
  } vrs_cfg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] reader;
    logic [LINE_W-1:0] line;
    logic [63:0] bits;
    logic [7:0] crc;
  } vrs_word_t;

  typedef struct packed {
    logic [31:0] time_bits;
    logic [31:0] user_bits;
    vrs_tkind_t time_kind;
    vrs_ukind_t user_kind;
    logic edge_used;
    logic [3:0] film_type;
    logic [1:0] film_rate;
    logic edge_style;
    logic [1:0] edge_fmt;
  } vrs_disp_t;
endpackage : vrs_pkg

// >>> hw/vrs_word_check.sv
// Line range gate and checksum check for one reader.
`timescale 1ns/1ps
module vrs_word_check #(
  parameter logic [7:0] FILM_KEY_SEED = 8'h5A,
  parameter logic [7:0] CHECKSUM_A_SEED = 8'hA5
) (
  input wire vrs_pkg::vrs_word_t word_i,
  input wire logic [vrs_pkg::LINE_W-1:0] start_i,
  input wire logic [vrs_pkg::LINE_W-1:0] end_i,
  input wire vrs_pkg::vrs_crc_t crc_sel_i,
  output logic in_range_o,
  output logic crc_ok_o
);
  logic [7:0] sum;
  logic [7:0] seed;

  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum ^ word_i.bits[8*i +: 8];
    end
    case (crc_sel_i)
      vrs_pkg::CRC_FILM_KEY: seed = FILM_KEY_SEED;
      vrs_pkg::CRC_CHECKSUM_A: seed = CHECKSUM_A_SEED;
      default: seed = 8'h00;
    endcase
    crc_ok_o = (word_i.crc == (sum ^ seed));
    in_range_o = (word_i.line >= start_i) && (word_i.line <= end_i);
  end
endmodule : vrs_word_check

// >>> hw/vrs_mode_map.sv
// Effective mode, checksum variant and field meaning for one reader.
`timescale 1ns/1ps
module vrs_mode_map #(
  parameter int READER_ID = 0
) (
  input wire vrs_pkg::vrs_cfg_t cfg_i,
  input wire logic three_line_assignment_i,
  output vrs_pkg::vrs_cfg_t eff_o,
  output vrs_pkg::vrs_crc_t crc_sel_o,
  output vrs_pkg::vrs_tkind_t time_kind_o,
  output vrs_pkg::vrs_ukind_t user_kind_o,
  output logic edge_used_o
);
  always_comb begin
    eff_o = cfg_i;
    if (three_line_assignment_i) begin
      eff_o.mode = vrs_pkg::FORCED_MODE;
      eff_o.crc_alt = vrs_pkg::FORCED_CRC_ALT;
      eff_o.edge_style = vrs_pkg::FORCED_EDGE_STYLE;
      eff_o.edge_fmt = vrs_pkg::FORCED_EDGE_FMT;
    end
    if (!eff_o.crc_alt) begin
      crc_sel_o = vrs_pkg::CRC_STANDARD;
    end else if (READER_ID == 2) begin
      crc_sel_o = vrs_pkg::CRC_CHECKSUM_A;
    end else begin
      crc_sel_o = vrs_pkg::CRC_FILM_KEY;
    end
    case (eff_o.mode)
      vrs_pkg::MODE_TIME_TIME: begin
        time_kind_o = vrs_pkg::TK_TIME;
        user_kind_o = vrs_pkg::UK_TIME;
      end
      vrs_pkg::MODE_TIME_EDGE: begin
        time_kind_o = vrs_pkg::TK_TIME;
        user_kind_o = vrs_pkg::UK_EDGE;
      end
      vrs_pkg::MODE_KEY_INFO_PLUS_EDGE: begin
        time_kind_o = vrs_pkg::TK_KEY_INFO;
        user_kind_o = vrs_pkg::UK_EDGE;
      end
      vrs_pkg::MODE_DATA_DATA: begin
        time_kind_o = vrs_pkg::TK_NUMERIC;
        user_kind_o = vrs_pkg::UK_NUMERIC;
      end
      vrs_pkg::MODE_TIME_DATE: begin
        time_kind_o = vrs_pkg::TK_TIME;
        user_kind_o = vrs_pkg::UK_DATE;
      end
      default: begin
        time_kind_o = vrs_pkg::TK_TIME;
        user_kind_o = vrs_pkg::UK_NUMERIC;
      end
    endcase
    edge_used_o = (user_kind_o == vrs_pkg::UK_EDGE);
  end
endmodule : vrs_mode_map

// >>> hw/vrs_reader_setup.sv
// Reader setup decoder: registers, gating, checksum and field mapping.
`timescale 1ns/1ps
module vrs_reader_setup #(
  parameter logic [7:0] FILM_KEY_SEED = 8'h5A,
  parameter logic [7:0] CHECKSUM_A_SEED = 8'hA5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire vrs_pkg::vrs_word_t word_i,
  output vrs_pkg::vrs_disp_t [vrs_pkg::NUM_READERS-1:0] disp_o,
  output logic [vrs_pkg::NUM_READERS-1:0] disp_upd_o
);
  localparam int NR = vrs_pkg::NUM_READERS;
  localparam int LW = vrs_pkg::LINE_W;

  vrs_pkg::vrs_asgn_t assign_sel;
  vrs_pkg::vrs_cfg_t [NR-1:0] cfg;
  logic [NR-1:0][LW-1:0] line_start;
  logic [NR-1:0][LW-1:0] line_end;
  logic [NR-1:0] data_valid;
  logic [NR-1:0] crc_err;

  logic three_line_assignment;
  logic [NR-1:0] is_vitc;
  vrs_pkg::vrs_cfg_t [NR-1:0] eff;
  vrs_pkg::vrs_crc_t [NR-1:0] crc_sel;
  vrs_pkg::vrs_tkind_t [NR-1:0] time_kind;
  vrs_pkg::vrs_ukind_t [NR-1:0] user_kind;
  logic [NR-1:0] edge_used;
  logic [NR-1:0] in_range;
  logic [NR-1:0] crc_ok;
  logic [NR-1:0] hit;
  logic [NR-1:0] accept;
  logic [NR-1:0] reject;

  logic ph_wr;
  logic ph_rd;
  logic rd_done;
  logic [vrs_pkg::AW-1:0] ph_addr;
  logic take;
  logic [1:0] rsel;
  logic rhit;
  logic [3:0] rofs;
  logic [3:0] rpage;
  logic [31:0] next_rdata;

  assign three_line_assignment = (assign_sel == vrs_pkg::ASG_THREE_LINE);

  always_comb begin
    case (assign_sel)
      vrs_pkg::ASG_LTC_VITC_OFF: is_vitc = 3'h2;
      vrs_pkg::ASG_VITC_VITC_OFF: is_vitc = 3'h3;
      vrs_pkg::ASG_VITC_X3: is_vitc = 3'h7;
      vrs_pkg::ASG_THREE_LINE: is_vitc = 3'h7;
      vrs_pkg::ASG_AUTO_OFF_OFF: is_vitc = 3'h1;
      default: is_vitc = 3'h0;
    endcase
  end

  for (genvar r = 0; r < NR; r++) begin : g_rdr
    vrs_mode_map #(
      .READER_ID(r)
    ) u_map (
      .cfg_i(cfg[r]),
      .three_line_assignment_i(three_line_assignment),
      .eff_o(eff[r]),
      .crc_sel_o(crc_sel[r]),
      .time_kind_o(time_kind[r]),
      .user_kind_o(user_kind[r]),
      .edge_used_o(edge_used[r])
    );
    vrs_word_check #(
      .FILM_KEY_SEED(FILM_KEY_SEED),
      .CHECKSUM_A_SEED(CHECKSUM_A_SEED)
    ) u_chk (
      .word_i(word_i),
      .start_i(line_start[r]),
      .end_i(line_end[r]),
      .crc_sel_i(crc_sel[r]),
      .in_range_o(in_range[r]),
      .crc_ok_o(crc_ok[r])
    );
    assign hit[r] = word_i.valid && (word_i.reader == 2'(r)) && is_vitc[r]
                    && in_range[r];
    assign accept[r] = hit[r] && crc_ok[r];
    assign reject[r] = hit[r] && !crc_ok[r];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_o <= '0;
      disp_upd_o <= '0;
    end else begin
      disp_upd_o <= accept;
      for (int r = 0; r < NR; r++) begin
        if (accept[r]) begin
          disp_o[r].time_bits <= word_i.bits[31:0];
          disp_o[r].user_bits <= word_i.bits[63:32];
          disp_o[r].time_kind <= time_kind[r];
          disp_o[r].user_kind <= user_kind[r];
          disp_o[r].edge_used <= edge_used[r];
          if (edge_used[r]) begin
            disp_o[r].film_type <= eff[r].film_type;
            disp_o[r].film_rate <= eff[r].film_rate;
            disp_o[r].edge_style <= eff[r].edge_style;
            disp_o[r].edge_fmt <= eff[r].edge_fmt;
          end else begin
            disp_o[r].film_type <= 4'h0;
            disp_o[r].film_rate <= 2'h0;
            disp_o[r].edge_style <= 1'b0;
            disp_o[r].edge_fmt <= 2'h0;
          end
        end
      end
    end
  end

  assign take = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = !(ph_rd && !rd_done);
  assign hresp_o = 1'b0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= '0;
    end else if (hready_i) begin
      ph_wr <= take && hwrite_i;
      ph_rd <= take && !hwrite_i;
      if (take) begin
        ph_addr <= haddr_i[vrs_pkg::AW-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done <= 1'b0;
      hrdata_o <= '0;
    end else if (ph_rd && !rd_done) begin
      rd_done <= 1'b1;
      hrdata_o <= next_rdata;
    end else if (hready_i) begin
      rd_done <= 1'b0;
    end
  end

  always_comb begin
    rofs = ph_addr[3:0];
    rpage = ph_addr[7:4] - vrs_pkg::RDR_PAGE_FIRST;
    rsel = rpage[1:0];
    rhit = (ph_addr[7:4] >= vrs_pkg::RDR_PAGE_FIRST)
           && (rpage < 4'(NR)) && (ph_addr[1:0] == 2'h0);
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ph_addr == vrs_pkg::ADDR_ASSIGN) begin
      next_rdata[2:0] = assign_sel;
    end else if (ph_addr == vrs_pkg::ADDR_STATUS) begin
      next_rdata[vrs_pkg::STAT_VALID_LSB +: NR] = data_valid;
      next_rdata[vrs_pkg::STAT_CRCERR_LSB +: NR] = crc_err;
    end else if (rhit) begin
      case (rofs)
        vrs_pkg::OFS_CFG: begin
          next_rdata[vrs_pkg::CFG_MODE_LSB +: 3] = cfg[rsel].mode;
          next_rdata[vrs_pkg::CFG_CRC_ALT_BIT] = cfg[rsel].crc_alt;
          next_rdata[vrs_pkg::CFG_FILM_TYPE_LSB +: 4] = cfg[rsel].film_type;
          next_rdata[vrs_pkg::CFG_FILM_RATE_LSB +: 2] = cfg[rsel].film_rate;
          next_rdata[vrs_pkg::CFG_EDGE_STYLE_BIT] = cfg[rsel].edge_style;
          next_rdata[vrs_pkg::CFG_EDGE_FMT_LSB +: 2] = cfg[rsel].edge_fmt;
        end
        vrs_pkg::OFS_LINES: begin
          next_rdata[vrs_pkg::LINES_START_LSB +: LW] = line_start[rsel];
          next_rdata[vrs_pkg::LINES_END_LSB +: LW] = line_end[rsel];
        end
        vrs_pkg::OFS_TIME: next_rdata = disp_o[rsel].time_bits;
        vrs_pkg::OFS_USER: next_rdata = disp_o[rsel].user_bits;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      assign_sel <= vrs_pkg::ASG_LTC_VITC_OFF;
    end else if (ph_wr && (ph_addr == vrs_pkg::ADDR_ASSIGN)) begin
      assign_sel <= vrs_pkg::vrs_asgn_t'(hwdata_i[2:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '0;
      line_start <= {NR{vrs_pkg::LINE_START_RST}};
      line_end <= {NR{vrs_pkg::LINE_END_RST}};
    end else if (ph_wr && rhit) begin
      if (rofs == vrs_pkg::OFS_CFG) begin
        cfg[rsel].mode <= vrs_pkg::vrs_mode_t'(
          hwdata_i[vrs_pkg::CFG_MODE_LSB +: 3]);
        cfg[rsel].crc_alt <= hwdata_i[vrs_pkg::CFG_CRC_ALT_BIT];
        cfg[rsel].film_type <= hwdata_i[vrs_pkg::CFG_FILM_TYPE_LSB +: 4];
        cfg[rsel].film_rate <= hwdata_i[vrs_pkg::CFG_FILM_RATE_LSB +: 2];
        cfg[rsel].edge_style <= hwdata_i[vrs_pkg::CFG_EDGE_STYLE_BIT];
        cfg[rsel].edge_fmt <= hwdata_i[vrs_pkg::CFG_EDGE_FMT_LSB +: 2];
      end else if (rofs == vrs_pkg::OFS_LINES) begin
        line_start[rsel] <= hwdata_i[vrs_pkg::LINES_START_LSB +: LW];
        line_end[rsel] <= hwdata_i[vrs_pkg::LINES_END_LSB +: LW];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_valid <= '0;
      crc_err <= '0;
    end else begin
      data_valid <= data_valid | accept;
      if (ph_wr && (ph_addr == vrs_pkg::ADDR_STATUS)) begin
        crc_err <= (crc_err & ~hwdata_i[vrs_pkg::STAT_CRCERR_LSB +: NR])
                   | reject;
      end else begin
        crc_err <= crc_err | reject;
      end
    end
  end

  // Checks on the reader selected by the incoming word.
  logic [LW-1:0] cur_start;
  logic [LW-1:0] cur_end;
  logic cur_vitc;
  logic cur_ok;
  logic cur_hit;
  always_comb begin
    cur_start = '0;
    cur_end = '0;
    cur_vitc = 1'b0;
    cur_ok = 1'b0;
    cur_hit = 1'b0;
    if (word_i.reader < 2'(NR)) begin
      cur_start = line_start[word_i.reader];
      cur_end = line_end[word_i.reader];
      cur_vitc = is_vitc[word_i.reader];
      cur_ok = crc_ok[word_i.reader];
      cur_hit = hit[word_i.reader];
    end
  end

  property p_range_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    (|disp_upd_o) |-> ($past(word_i.line) >= $past(cur_start))
                      && ($past(word_i.line) <= $past(cur_end));
  endproperty
  a_range_gate: assert property (p_range_gate)
    else $error("update from a line outside the range");

  property p_vitc_only;
    @(posedge clk_i) disable iff (!rst_n_i)
    (|disp_upd_o) |-> $past(cur_vitc) && $past(word_i.valid);
  endproperty
  a_vitc_only: assert property (p_vitc_only)
    else $error("update on a reader not reading vertical code");

  property p_crc_choice;
    @(posedge clk_i) disable iff (!rst_n_i)
    (crc_sel[2] != vrs_pkg::CRC_FILM_KEY)
    && (crc_sel[0] != vrs_pkg::CRC_CHECKSUM_A)
    && (crc_sel[1] != vrs_pkg::CRC_CHECKSUM_A);
  endproperty
  a_crc_choice: assert property (p_crc_choice)
    else $error("checksum variant not offered on this reader");

  property p_good_only;
    @(posedge clk_i) disable iff (!rst_n_i)
    (|disp_upd_o) |-> $past(cur_ok);
  endproperty
  a_good_only: assert property (p_good_only)
    else $error("update from a word that failed its checksum");

  property p_bad_dropped;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cur_hit && !cur_ok) |=> $stable(disp_o) && (disp_upd_o == '0)
                             && (crc_err != '0);
  endproperty
  a_bad_dropped: assert property (p_bad_dropped)
    else $error("failed word changed the decoded values");

  property p_dual_numeric;
    @(posedge clk_i) disable iff (!rst_n_i)
    disp_upd_o[0] && ($past(eff[0].mode) == vrs_pkg::MODE_DATA_DATA)
    |-> (disp_o[0].time_kind == vrs_pkg::TK_NUMERIC)
        && (disp_o[0].user_kind == vrs_pkg::UK_NUMERIC);
  endproperty
  a_dual_numeric: assert property (p_dual_numeric)
    else $error("dual numeric mode decoded wrongly");

  property p_key_info;
    @(posedge clk_i) disable iff (!rst_n_i)
    disp_upd_o[1]
    && ($past(eff[1].mode) == vrs_pkg::MODE_KEY_INFO_PLUS_EDGE)
    |-> (disp_o[1].time_kind == vrs_pkg::TK_KEY_INFO)
        && (disp_o[1].user_kind == vrs_pkg::UK_EDGE)
        && (disp_o[1].edge_fmt == $past(eff[1].edge_fmt));
  endproperty
  a_key_info: assert property (p_key_info)
    else $error("key info mode decoded wrongly");

  property p_edge_fields;
    @(posedge clk_i) disable iff (!rst_n_i)
    disp_upd_o[0] && !disp_o[0].edge_used
    |-> (disp_o[0].film_type == 4'h0) && (disp_o[0].edge_fmt == 2'h0);
  endproperty
  a_edge_fields: assert property (p_edge_fields)
    else $error("edge settings leaked outside edge modes");

  property p_three_line;
    @(posedge clk_i) disable iff (!rst_n_i)
    three_line_assignment |-> (eff[2].mode == vrs_pkg::FORCED_MODE)
                              && (crc_sel[2] == vrs_pkg::CRC_CHECKSUM_A)
                              && (eff[0].edge_fmt == vrs_pkg::FORCED_EDGE_FMT);
  endproperty
  a_three_line: assert property (p_three_line)
    else $error("three line assignment did not force settings");

  property p_read_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase length wrong");
endmodule : vrs_reader_setup

// >>> sim/vrs_video_src.sv
// Video source model that delivers recovered timecode words.
`timescale 1ns/1ps
module vrs_video_src #(
  parameter logic [7:0] FILM_KEY_SEED = 8'h5A,
  parameter logic [7:0] CHECKSUM_A_SEED = 8'hA5
) (
  input wire logic clk_i,
  output vrs_pkg::vrs_word_t word_o
);
  initial word_o = '0;
  // Sends one word; kind 0..2 picks the check variant, 3 spoils it.
  task automatic send(input logic [1:0] rdr, input logic [9:0] ln,
                      input logic [63:0] b, input int kind);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s ^ b[8*i +: 8];
    case (kind)
      1: s = s ^ FILM_KEY_SEED;
      2: s = s ^ CHECKSUM_A_SEED;
      3: s = s ^ 8'h3C;
      default: s = s;
    endcase
    @(posedge clk_i);
    word_o <= '{valid: 1'b1, reader: rdr, line: ln, bits: b, crc: s};
    @(posedge clk_i);
    // Released fields show the inverse so stale values cannot match.
    word_o <= '{valid: 1'b0, reader: ~rdr, line: ~ln, bits: ~b, crc: ~s};
  endtask : send
endmodule : vrs_video_src

// >>> sim/vrs_reader_setup_tb.sv
// Self-checking testbench for the reader setup decoder.
`timescale 1ns/1ps
module vrs_reader_setup_tb;
  logic clk_i, rst_n_i, hsel, hwrite, hreadyout_o, hresp_o;
  logic [31:0] haddr, hwdata, hrdata_o, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, disp_upd_o;
  vrs_pkg::vrs_word_t vword;
  vrs_pkg::vrs_disp_t [vrs_pkg::NUM_READERS-1:0] disp_o;
  vrs_pkg::vrs_disp_t ed [3];
  int bad_count, n_checks, asg, sv, se, s;
  int md[3], alt[3], ft[3], fr[3], es[3], ef[3], st[3], en[3];
  int tk[8] = '{0, 0, 0, 2, 1, 0, 0, 0};
  int uk[8] = '{0, 1, 2, 2, 0, 3, 0, 0};

  vrs_reader_setup vrs_reader_setup_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .word_i(vword), .disp_o(disp_o), .disp_upd_o(disp_upd_o));
  vrs_video_src vrs_video_src_i (.clk_i(clk_i), .word_o(vword));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task close_out;
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task chk(input logic [79:0] g, input logic [79:0] e);
    n_checks++;
    if (g !== e) begin
      $display("Error t=%0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  // Waits for hready as it will be sampled at the coming rising edge.
  task wait_rdy;
    int n;
    n = 0;
    @(negedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        close_out;
      end
      @(negedge clk_i);
    end
  endtask : wait_rdy

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata_o;
    chk(hresp_o, 80'h0);
  endtask : ahb

  function logic [31:0] ra(input int r, input logic [3:0] o);
    ra = {24'h000000, vrs_pkg::RDR_PAGE_FIRST + 4'(r), o};
  endfunction : ra

  function int vitc(input int r);
    case (asg)
      0: return int'(r == 1);
      1: return int'(r < 2);
      3: return int'(r == 0);
      default: return 1;
    endcase
  endfunction : vitc

  function int want(input int r);
    int a;
    a = (asg == 4) ? 1 : alt[r];
    return (a == 0) ? 0 : ((r < 2) ? 1 : 2);
  endfunction : want

  task cfg(input int r, input int m, input int a);
    md[r] = m;
    alt[r] = a;
    ft[r] = $urandom_range(15, 0);
    fr[r] = $urandom_range(3, 0);
    es[r] = $urandom_range(1, 0);
    ef[r] = $urandom_range(3, 0);
    ahb(1'b1, ra(r, vrs_pkg::OFS_CFG), 32'(m | a << 3 | ft[r] << 4 |
        fr[r] << 8 | es[r] << 10 | ef[r] << 11));
  endtask : cfg

  task word(input int r, input int ln, input int k);
    logic [63:0] b;
    int ok, m;
    vrs_pkg::vrs_disp_t e;
    b = {$urandom, $urandom};
    vrs_video_src_i.send(2'(r), 10'(ln), b, k);
    ok = 0;
    if (r < 3 && vitc(r) != 0 && ln >= st[r] && ln <= en[r]) begin
      if (k == want(r)) begin
        ok = 1;
        m = (asg == 4) ? 0 : md[r];
        e = '0;
        e.time_bits = b[31:0];
        e.user_bits = b[63:32];
        e.time_kind = vrs_pkg::vrs_tkind_t'(tk[m]);
        e.user_kind = vrs_pkg::vrs_ukind_t'(uk[m]);
        if (uk[m] == 2) begin
          e.edge_used = 1'b1;
          e.film_type = 4'(ft[r]);
          e.film_rate = 2'(fr[r]);
          e.edge_style = 1'(es[r]);
          e.edge_fmt = 2'(ef[r]);
        end
        ed[r] = e;
        sv = sv | (1 << r);
      end else begin
        se = se | (1 << r);
      end
    end
    #1;
    chk(disp_upd_o, ok ? (1 << r) : 0);
    if (r < 3) chk(disp_o[r], ed[r]);
  endtask : word

  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rst_n_i = 1'b0;
    bad_count = 0;
    n_checks = 0;
    asg = 0;
    sv = 0;
    se = 0;
    for (int r = 0; r < 3; r++) begin
      md[r] = 0;
      alt[r] = 0;
      st[r] = 10;
      en[r] = 20;
      ed[r] = '0;
    end
    void'($urandom(32'h1894BFB2));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values and an unmapped place.
    ahb(1'b0, vrs_pkg::ADDR_ASSIGN, 32'h0);
    chk(rd, 80'h0);
    for (int r = 0; r < 3; r++) begin
      ahb(1'b0, ra(r, vrs_pkg::OFS_LINES), 32'h0);
      chk(rd, 80'h0014000A);
      ahb(1'b0, ra(r, vrs_pkg::OFS_CFG), 32'h0);
      chk(rd, 80'h0);
    end
    ahb(1'b1, 32'h000000F0, 32'hFFFFFFFF);
    ahb(1'b0, 32'h000000F0, 32'h0);
    chk(rd, 80'h0);
    // Line range edges on every reader, then an invalid reader index.
    asg = 2;
    ahb(1'b1, vrs_pkg::ADDR_ASSIGN, 32'h2);
    for (int r = 0; r < 3; r++) begin
      s = $urandom_range(400, 30);
      st[r] = s;
      en[r] = s + 2;
      ahb(1'b1, ra(r, vrs_pkg::OFS_LINES), 32'(s | (s + 2) << 16));
      for (int d = -1; d < 4; d++) word(r, s + d, 0);
    end
    word(3, 40, 0);
    // Every check variant against both selections of each reader.
    for (int r = 0; r < 3; r++)
      for (int a = 0; a < 2; a++) begin
        cfg(r, 0, a);
        for (int k = 0; k < 4; k++) word(r, st[r], k);
      end
    ahb(1'b0, vrs_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'(sv | se << 4));
    ahb(1'b1, vrs_pkg::ADDR_STATUS, 32'h00000070);
    se = 0;
    ahb(1'b0, vrs_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'(sv));
    // All mode codes with random film settings.
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 8; m++) begin
        cfg(r, m, int'(m == 3));
        word(r, en[r], want(r));
      end
    ahb(1'b0, ra(1, vrs_pkg::OFS_TIME), 32'h0);
    chk(rd, ed[1].time_bits);
    ahb(1'b0, ra(1, vrs_pkg::OFS_USER), 32'h0);
    chk(rd, ed[1].user_bits);
    cfg(2, 3, 1);
    // Every assignment code, the three-line one last.
    for (int a = 0; a < 5; a++) begin
      asg = a;
      ahb(1'b1, vrs_pkg::ADDR_ASSIGN, 32'(a));
      ahb(1'b0, vrs_pkg::ADDR_ASSIGN, 32'h0);
      chk(rd, 80'(a));
      for (int r = 0; r < 3; r++) begin
        word(r, st[r], want(r));
        word(r, st[r], 0);
      end
    end
    close_out;
  end
endmodule : vrs_reader_setup_tb
